// ### design/bf16_convert_pkg.sv
// Constants and types shared by the brain-float conversion datapath.
package bf16_convert_pkg;

    // Register width of the scalar float file and number of vector lanes per beat.
    localparam int unsigned FLEN       = 64;
    localparam int unsigned LANES      = 2;
    localparam int unsigned SP_W       = 32;
    localparam int unsigned BF_W       = 16;
    // Low bits appended when widening, and ones written above a scalar result.
    localparam logic [15:0] WIDEN_FILL = 16'h0000;
    localparam logic [31:0] BOX_SP     = 32'hffffffff;
    localparam logic [47:0] BOX_BF     = 48'hffffffffffff;
    localparam logic [31:0] VEC_PAD    = 32'h00000000;
    // Canonical quiet not-a-number patterns.
    localparam logic [15:0] CANON_BF   = 16'h7fc0;
    localparam logic [31:0] CANON_SP   = 32'h7fc00000;
    localparam logic [7:0]  EXP_MAX    = 8'hff;
    localparam logic [7:0]  EXP_ZERO   = 8'h00;

    // Rounding-mode codes.
    localparam logic [2:0] round_nearest_even          = 3'h0;
    localparam logic [2:0] round_toward_zero           = 3'h1;
    localparam logic [2:0] round_down                  = 3'h2;
    localparam logic [2:0] round_up_mode               = 3'h3;
    localparam logic [2:0] round_nearest_max_magnitude = 3'h4;

    typedef enum logic [1:0] {
        scalar_narrow_to_bfloat,
        scalar_widen_from_bfloat,
        vector_narrow_to_bfloat,
        vector_widen_from_bfloat
    } conv_op_t;

endpackage : bf16_convert_pkg

// ### design/bf16_fp32_convert_flags.sv
// Brain-float and single-precision conversion datapath with exception flags.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RULE1) Tininess for underflow is judged on the rounded value, not the unrounded one.
// (RULE2) Tininess uses a second rounding with unbounded exponent on a normalized significand.
// (RULE3) Delivered result rounds the denormal value; underflow may flag a normal result.
// (RULE4) Underflow is flagged only when the result is tiny and also inexact.
// (RULE5) Every underflow also raises inexact for the same operation.
// (RULE6) Scalar option provides single precision to brain-float narrowing.
// (RULE7) Scalar option provides brain-float to single precision widening, no other formats.
// (RULE8) Scalar option needs single precision and half-float load, store, both moves.
// (RULE9) Vector option provides element-wise narrowing and widening between both formats.
// (RULE10) Vector option needs the full vector unit or embedded_vector_sp_subset.
// (RULE11) Widening multiply-accumulate option needs both scalar and vector options.
// (RULE12) Every brain-float option needs single-precision support.
// (RULE13) Widening normal or infinite input puts it high and zeros the low 16 bits.
// (RULE14) Scalar single-precision results have all bits above the low 32 set.
// (RULE15) Any quiet not-a-number brain-float result is the canonical 16-bit pattern.
// (RULE16) Narrowing honours the five three-bit rounding-mode codes.
// (RULE17) Underflow and inexact return to the pipeline together with the result.
module bf16_fp32_convert_flags #(
    parameter bit HAS_SP          = 1'b1,
    parameter bit HAS_HALF_MOVES  = 1'b1,
    parameter bit HAS_SCALAR_BF   = 1'b1,
    parameter bit HAS_FULL_VECTOR = 1'b1,
    parameter bit HAS_EMBED_VEC   = 1'b0,
    parameter bit HAS_VECTOR_BF   = 1'b1,
    parameter bit HAS_WMA_BF      = 1'b1
) (
    // Clock and reset
    input  wire logic                              i_clk,
    input  wire logic                              i_reset,
    // Operation issue from the pipeline
    input  wire logic                              i_valid,
    input  wire bf16_convert_pkg::conv_op_t        i_op,
    input  wire logic [2:0]                        i_rm,
    input  wire logic [bf16_convert_pkg::FLEN-1:0] i_src,
    // Result and flags back to the pipeline
    output logic                                   o_valid,
    output logic                                   o_illegal,
    output logic [bf16_convert_pkg::FLEN-1:0]      o_result,
    output logic                                   o_flag_invalid,
    output logic                                   o_flag_overflow,
    output logic                                   o_flag_underflow,
    output logic                                   o_flag_inexact,
    // Options actually present after dependency checks
    output logic                                   o_has_scalar,
    output logic                                   o_has_vector,
    output logic                                   o_has_wma
);

    // An option whose prerequisites are missing is simply absent.
    localparam bit SCALAR_OK = HAS_SCALAR_BF && HAS_SP && HAS_HALF_MOVES; // RULE8 RULE12
    localparam bit VECTOR_OK = HAS_VECTOR_BF && HAS_SP
                               && (HAS_FULL_VECTOR || HAS_EMBED_VEC);     // RULE10 RULE12
    localparam bit WMA_OK    = HAS_WMA_BF && SCALAR_OK && VECTOR_OK;      // RULE11 RULE12

    function automatic logic round_inc(input logic [2:0] rm, input logic sgn,
                                       input logic lsb, input logic rnd, input logic stk);
        logic inc;
        inc = 1'b0;
        case (rm) // RULE16
            bf16_convert_pkg::round_nearest_even:          inc = rnd & (stk | lsb);
            bf16_convert_pkg::round_toward_zero:           inc = 1'b0;
            bf16_convert_pkg::round_down:                  inc = sgn & (rnd | stk);
            bf16_convert_pkg::round_up_mode:               inc = ~sgn & (rnd | stk);
            bf16_convert_pkg::round_nearest_max_magnitude: inc = rnd;
            default:                                       inc = 1'b0;
        endcase
        return inc;
    endfunction : round_inc

    // Returns {invalid, overflow, underflow, inexact, bf16}.
    function automatic logic [19:0] narrow(input logic [31:0] x, input logic [2:0] rm);
        logic        inc;
        logic        inc_unb;
        logic        nx;
        logic        of;
        logic        tiny;
        logic [15:0] mag;
        logic [19:0] r;
        inc     = 1'b0;
        inc_unb = 1'b0;
        nx      = 1'b0;
        of      = 1'b0;
        tiny    = 1'b0;
        mag     = 16'h0000;
        r       = 20'h00000;
        if (x[30:23] == bf16_convert_pkg::EXP_MAX && x[22:0] != 23'h000000) begin
            r = {~x[22], 3'h0, bf16_convert_pkg::CANON_BF}; // RULE15
        end else if (x[30:23] == bf16_convert_pkg::EXP_MAX || x[30:0] == 31'h00000000) begin
            r = {4'h0, x[31:16]};
        end else begin
            // Both formats share the exponent field, so a denormal source rounds as a
            // denormal result with no extra shifting.
            inc  = round_inc(rm, x[31], x[16], x[15], |x[14:0]); // RULE3
            mag  = {1'b0, x[30:16]} + {15'h0000, inc};
            nx   = x[15] | (|x[14:0]);
            of   = (mag[14:7] == bf16_convert_pkg::EXP_MAX);
            // Unbounded-exponent rounding: a denormal with its top bit set keeps eight
            // significant bits from bit 22; only that case can round up to the normal range.
            inc_unb = round_inc(rm, x[31], x[15], x[14], |x[13:0]); // RULE2
            tiny = (x[30:23] == bf16_convert_pkg::EXP_ZERO)
                   && !((x[22:15] == 8'hff) && inc_unb); // RULE1
            r    = {1'b0, of, tiny & nx, nx | of, x[31], mag[14:0]}; // RULE4 RULE5
        end
        return r;
    endfunction : narrow

    // Returns {invalid, fp32}; the widening is always exact.
    function automatic logic [32:0] widen(input logic [15:0] b);
        logic [32:0] r;
        r = {1'b0, b, bf16_convert_pkg::WIDEN_FILL}; // RULE13
        if (b[14:7] == bf16_convert_pkg::EXP_MAX && b[6:0] != 7'h00) begin
            r = {~b[6], bf16_convert_pkg::CANON_SP};
        end
        return r;
    endfunction : widen

    logic                              valid_ff;
    logic                              illegal_ff;
    logic [bf16_convert_pkg::FLEN-1:0] result_ff;
    logic                              nv_ff;
    logic                              of_ff;
    logic                              uf_ff;
    logic                              nx_ff;
    logic                              nxt_valid;
    logic                              nxt_illegal;
    logic [bf16_convert_pkg::FLEN-1:0] nxt_result;
    logic                              nxt_nv;
    logic                              nxt_of;
    logic                              nxt_uf;
    logic                              nxt_nx;

    always_comb begin
        logic        legal;
        logic [19:0] n;
        logic [32:0] w;
        legal       = 1'b0;
        n           = 20'h00000;
        w           = 33'h000000000;
        nxt_result  = result_ff;
        nxt_nv      = 1'b0;
        nxt_of      = 1'b0;
        nxt_uf      = 1'b0;
        nxt_nx      = 1'b0;
        case (i_op)
            bf16_convert_pkg::scalar_narrow_to_bfloat:  legal = SCALAR_OK;
            bf16_convert_pkg::scalar_widen_from_bfloat: legal = SCALAR_OK;
            default:                                    legal = VECTOR_OK;
        endcase
        // Narrowing with a reserved rounding code is refused; widening ignores the mode.
        if ((i_op == bf16_convert_pkg::scalar_narrow_to_bfloat
             || i_op == bf16_convert_pkg::vector_narrow_to_bfloat)
            && i_rm > bf16_convert_pkg::round_nearest_max_magnitude) begin
            legal = 1'b0; // RULE16
        end
        nxt_valid   = i_valid & legal;
        nxt_illegal = i_valid & ~legal;
        if (nxt_valid) begin
            case (i_op)
                bf16_convert_pkg::scalar_narrow_to_bfloat: begin
                    n          = narrow(i_src[31:0], i_rm); // RULE6
                    nxt_result = {bf16_convert_pkg::BOX_BF, n[15:0]};
                    {nxt_nv, nxt_of, nxt_uf, nxt_nx} = n[19:16]; // RULE17
                end
                bf16_convert_pkg::scalar_widen_from_bfloat: begin
                    w          = widen(i_src[15:0]); // RULE7
                    nxt_result = {bf16_convert_pkg::BOX_SP, w[31:0]}; // RULE14
                    nxt_nv     = w[32];
                end
                bf16_convert_pkg::vector_narrow_to_bfloat: begin
                    nxt_result = {bf16_convert_pkg::VEC_PAD, bf16_convert_pkg::VEC_PAD};
                    for (int k = 0; k < bf16_convert_pkg::LANES; k++) begin
                        n = narrow(i_src[k*bf16_convert_pkg::SP_W +: 32], i_rm); // RULE9
                        nxt_result[k*bf16_convert_pkg::BF_W +: 16] = n[15:0];
                        nxt_nv = nxt_nv | n[19];
                        nxt_of = nxt_of | n[18];
                        nxt_uf = nxt_uf | n[17];
                        nxt_nx = nxt_nx | n[16]; // RULE17
                    end
                end
                default: begin
                    for (int k = 0; k < bf16_convert_pkg::LANES; k++) begin
                        w = widen(i_src[k*bf16_convert_pkg::BF_W +: 16]); // RULE9
                        nxt_result[k*bf16_convert_pkg::SP_W +: 32] = w[31:0];
                        nxt_nv = nxt_nv | w[32];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            valid_ff   <= 1'b0;
            illegal_ff <= 1'b0;
            result_ff  <= '0;
            nv_ff      <= 1'b0;
            of_ff      <= 1'b0;
            uf_ff      <= 1'b0;
            nx_ff      <= 1'b0;
        end else begin
            valid_ff   <= nxt_valid;
            illegal_ff <= nxt_illegal;
            result_ff  <= nxt_result;
            nv_ff      <= nxt_nv;
            of_ff      <= nxt_of;
            uf_ff      <= nxt_uf;
            nx_ff      <= nxt_nx;
        end
    end

    // Option flags are constants but still leave through flip-flops like every output.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_has_scalar <= 1'b0;
            o_has_vector <= 1'b0;
            o_has_wma    <= 1'b0;
        end else begin
            o_has_scalar <= SCALAR_OK;
            o_has_vector <= VECTOR_OK;
            o_has_wma    <= WMA_OK; // RULE11
        end
    end

    assign o_valid          = valid_ff;
    assign o_illegal        = illegal_ff;
    assign o_result         = result_ff;
    assign o_flag_invalid   = nv_ff;
    assign o_flag_overflow  = of_ff;
    assign o_flag_underflow = uf_ff;
    assign o_flag_inexact   = nx_ff;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_scalar_narrow;
        i_valid && i_op == bf16_convert_pkg::scalar_narrow_to_bfloat && SCALAR_OK
        && i_rm <= bf16_convert_pkg::round_nearest_max_magnitude;
    endsequence

    sequence s_scalar_widen;
        i_valid && i_op == bf16_convert_pkg::scalar_widen_from_bfloat && SCALAR_OK;
    endsequence

    a_uf_sets_nx: assert property (o_valid && o_flag_underflow |-> o_flag_inexact) // RULE5
        else $error("Underflow raised without inexact.");
    a_exact_no_uf: assert property (s_scalar_narrow ##0 (i_src[15:0] == 16'h0000)
        |=> o_valid && !o_flag_underflow && !o_flag_inexact) // RULE4
        else $error("Exact narrowing raised underflow or inexact.");
    a_normal_no_tiny: assert property (s_scalar_narrow ##0 (i_src[30:23] != 8'h00)
        |=> !o_flag_underflow) // RULE1
        else $error("Normal source flagged as tiny.");
    a_tiny_rounds_up: assert property (s_scalar_narrow ##0 (i_src[30:14] == 17'h001ff)
        && (i_rm == bf16_convert_pkg::round_nearest_even)
        |=> o_result[15:0] == {$past(i_src[31]), 15'h0080} && !o_flag_underflow) // RULE2
        else $error("Unbounded rounding reached normal range yet flagged underflow.");
    a_denorm_uf: assert property (s_scalar_narrow ##0 (i_src[30:22] == 9'h000)
        && (i_src[15:0] != 16'h0000) |=> o_flag_underflow) // RULE3
        else $error("Inexact denormal narrowing missed underflow.");
    a_widen_boxed: assert property (s_scalar_widen ##0 (i_src[14:7] != 8'hff)
        |=> o_result == {32'hffffffff, $past(i_src[15:0]), 16'h0000}) // RULE13 RULE14
        else $error("Scalar widening result not shifted or not boxed.");
    a_narrow_nan: assert property (s_scalar_narrow ##0 (i_src[30:23] == 8'hff)
        && (i_src[22:0] != 23'h000000) |=> o_result[15:0] == 16'h7fc0) // RULE15
        else $error("Narrowed not-a-number is not canonical.");
    a_rtz_truncate: assert property (s_scalar_narrow ##0
        (i_rm == bf16_convert_pkg::round_toward_zero) ##0 (i_src[30:23] != 8'hff)
        |=> o_result[15:0] == $past(i_src[31:16]) && !o_flag_overflow) // RULE16
        else $error("Toward-zero narrowing did not truncate.");
    a_refused_op: assert property (i_valid && !VECTOR_OK
        && i_op == bf16_convert_pkg::vector_widen_from_bfloat
        |=> o_illegal && !o_valid) // RULE10
        else $error("Absent vector option accepted an operation.");
    a_one_answer: assert property (i_valid |=> o_valid != o_illegal) // RULE17
        else $error("Issued operation gave no single answer.");

endmodule : bf16_fp32_convert_flags
`default_nettype wire

// ### test/conv_pipe_model.sv
// Pipeline-side model that issues conversions and gathers the sticky exception flags.
`timescale 1ns/1ps
`default_nettype none
module conv_pipe_model (
    // Clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    // Issue towards the converter
    output logic                            o_valid,
    output bf16_convert_pkg::conv_op_t      o_op,
    output logic [2:0]                      o_rm,
    output logic [63:0]                     o_src,
    // Answers from the converter
    input  wire logic                       i_res_valid,
    input  wire logic [3:0]                 i_flags,
    // Accumulated exception flags
    output logic [3:0]                      o_sticky
);
    logic [3:0] sticky_ff;
    logic [3:0] nxt_sticky;

    // Called just after a falling edge; an idle operand flips so a stale value never looks valid.
    task automatic put(input logic v, input bf16_convert_pkg::conv_op_t op,
                       input logic [2:0] rm, input logic [63:0] src);
        o_valid = v;
        o_op    = op;
        o_rm    = rm;
        o_src   = v ? src : ~o_src;
    endtask : put

    always_comb begin
        nxt_sticky = sticky_ff | (i_res_valid ? i_flags : 4'h0);
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) sticky_ff <= 4'h0;
        else sticky_ff <= nxt_sticky;
    end

    assign o_sticky = sticky_ff;
endmodule : conv_pipe_model
`default_nettype wire

// ### test/tb_bf16_fp32_convert_flags.sv
// Self-checking bench for the brain-float conversion datapath.
`timescale 1ns/1ps
`default_nettype none
module tb_bf16_fp32_convert_flags;
    logic clk, rst, iv, r_v, r_il, o_il, hs, hv, hw, ohs, ohv, ohw, exp_v, exp_il, exp_oil;
    logic [2:0] irm;
    logic [63:0] isrc, r_res, exp_r;
    logic [3:0] r_fl, st, exp_fl, exp_st;
    logic [31:0] rnd, a;
    logic nhs, nhv, nhw, nh_il, exp_hil;
    logic [2:0] ns_has;
    bf16_convert_pkg::conv_op_t iop;
    int fails, n_tests, cycles;

    conv_pipe_model u_pipe (.i_clk(clk), .i_reset(rst), .o_valid(iv), .o_op(iop), .o_rm(irm),
        .o_src(isrc), .i_res_valid(r_v), .i_flags(r_fl), .o_sticky(st));
    bf16_fp32_convert_flags u_dut (.i_clk(clk), .i_reset(rst), .i_valid(iv), .i_op(iop),
        .i_rm(irm), .i_src(isrc), .o_valid(r_v), .o_illegal(r_il), .o_result(r_res),
        .o_flag_invalid(r_fl[3]), .o_flag_overflow(r_fl[2]), .o_flag_underflow(r_fl[1]),
        .o_flag_inexact(r_fl[0]), .o_has_scalar(hs), .o_has_vector(hv), .o_has_wma(hw));
    // Without any vector unit the vector and multiply-accumulate options must drop out.
    bf16_fp32_convert_flags #(.HAS_FULL_VECTOR(1'b0)) u_opt (.i_clk(clk), .i_reset(rst),
        .i_valid(iv), .i_op(iop), .i_rm(irm), .i_src(isrc), .o_valid(), .o_illegal(o_il),
        .o_result(), .o_flag_invalid(), .o_flag_overflow(), .o_flag_underflow(),
        .o_flag_inexact(), .o_has_scalar(ohs), .o_has_vector(ohv), .o_has_wma(ohw));
    // The embedded subset alone keeps the vector option, but missing half-float moves drop scalar.
    bf16_fp32_convert_flags #(.HAS_HALF_MOVES(1'b0), .HAS_FULL_VECTOR(1'b0),
        .HAS_EMBED_VEC(1'b1)) u_nohm (.i_clk(clk), .i_reset(rst), .i_valid(iv), .i_op(iop),
        .i_rm(irm), .i_src(isrc), .o_valid(), .o_illegal(nh_il), .o_result(),
        .o_flag_invalid(), .o_flag_overflow(), .o_flag_underflow(), .o_flag_inexact(),
        .o_has_scalar(nhs), .o_has_vector(nhv), .o_has_wma(nhw));
    // Without single precision no brain-float option may remain.
    bf16_fp32_convert_flags #(.HAS_SP(1'b0)) u_nosp (.i_clk(clk), .i_reset(rst),
        .i_valid(iv), .i_op(iop), .i_rm(irm), .i_src(isrc), .o_valid(), .o_illegal(),
        .o_result(), .o_flag_invalid(), .o_flag_overflow(), .o_flag_underflow(),
        .o_flag_inexact(), .o_has_scalar(ns_has[2]), .o_has_vector(ns_has[1]),
        .o_has_wma(ns_has[0]));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction : lfsr

    function automatic logic rinc(input logic [2:0] rm, input logic s, input logic l,
                                  input logic g, input logic t);
        case (rm)
            3'h0: return g & (t | l);
            3'h1: return 1'b0;
            3'h2: return s & (g | t);
            3'h3: return ~s & (g | t);
            default: return g;
        endcase
    endfunction : rinc

    // Returns {bf16, invalid, overflow, underflow, inexact}.
    function automatic logic [19:0] narrow(input logic [31:0] x, input logic [2:0] rm);
        logic inx, ovf, tiny;
        logic [15:0] r;
        inx = x[15] | (|x[14:0]);
        if (x[30:23] == 8'hff)
            return {(x[22:0] != 0) ? 16'h7fc0 : x[31:16], (x[22:0] != 0) & ~x[22], 3'h0};
        r = {x[31], x[30:16] + 15'(rinc(rm, x[31], x[16], x[15], |x[14:0]))};
        ovf = (r[14:7] == 8'hff);
        tiny = (x[30:23] == 8'h00) && (x[22:0] != 0)
            && !(&x[22:15] && rinc(rm, x[31], x[15], x[14], |x[13:0]));
        return {r, 1'b0, ovf, tiny & inx, inx | ovf};
    endfunction : narrow

    function automatic logic [32:0] widen(input logic [15:0] b);
        if (b[14:7] == 8'hff && b[6:0] != 0) return {~b[6], 32'h7fc00000};
        return {1'b0, b, 16'h0000};
    endfunction : widen

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic cyc(input logic v, input bf16_convert_pkg::conv_op_t op,
                       input logic [2:0] rm, input logic [63:0] src);
        logic [19:0] n0, n1;
        logic [32:0] w0, w1;
        logic nar;
        @(negedge clk);
        check("valid", 64'(r_v), 64'(exp_v));
        check("illegal", 64'(r_il), 64'(exp_il));
        check("result", r_res, exp_r);
        check("flags", 64'(r_fl), 64'(exp_fl));
        check("opt_illegal", 64'(o_il), 64'(exp_oil));
        check("nohm_illegal", 64'(nh_il), 64'(exp_hil));
        exp_st = exp_st | (exp_v ? exp_fl : 4'h0);
        n0 = narrow(src[31:0], rm);
        n1 = narrow(src[63:32], rm);
        w0 = widen(src[15:0]);
        w1 = widen(src[31:16]);
        nar = (op == bf16_convert_pkg::scalar_narrow_to_bfloat)
            || (op == bf16_convert_pkg::vector_narrow_to_bfloat);
        exp_il = v & nar & (rm > 3'h4);
        exp_v = v & ~exp_il;
        // Both vector encodings have the upper operation bit set.
        exp_oil = v & (exp_il | op[1]);
        // Scalar encodings have the upper operation bit clear.
        exp_hil = v & (exp_il | ~op[1]);
        exp_fl = 4'h0;
        if (exp_v) begin
            case (op)
                bf16_convert_pkg::scalar_narrow_to_bfloat: begin
                    exp_r = {48'hffffffffffff, n0[19:4]};
                    exp_fl = n0[3:0];
                end
                bf16_convert_pkg::scalar_widen_from_bfloat: begin
                    exp_r = {32'hffffffff, w0[31:0]};
                    exp_fl = {w0[32], 3'h0};
                end
                bf16_convert_pkg::vector_narrow_to_bfloat: begin
                    exp_r = {32'h00000000, n1[19:4], n0[19:4]};
                    exp_fl = n0[3:0] | n1[3:0];
                end
                default: begin
                    exp_r = {w1[31:0], w0[31:0]};
                    exp_fl = {w0[32] | w1[32], 3'h0};
                end
            endcase
        end
        u_pipe.put(v, op, rm, src);
    endtask : cyc

    task automatic sn(input logic [31:0] x, input logic [2:0] rm);
        cyc(1'b1, bf16_convert_pkg::scalar_narrow_to_bfloat, rm, {32'hffffffff, x});
    endtask : sn

    task automatic sw(input logic [15:0] b);
        cyc(1'b1, bf16_convert_pkg::scalar_widen_from_bfloat, 3'h7, {48'hffffffffffff, b});
    endtask : sw

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        fails = 0;
        n_tests = 0;
        cycles = 0;
        rnd = 32'hf7fc;
        exp_v = 1'b0; exp_il = 1'b0; exp_oil = 1'b0;
        exp_r = 64'h0; exp_fl = 4'h0; exp_st = 4'h0;
        exp_hil = 1'b0;
        u_pipe.put(1'b0, bf16_convert_pkg::scalar_narrow_to_bfloat, 3'h0, 64'h0);
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("has_opts", 64'({hs, hv, hw}), 64'(3'h7));
        check("opt_has", 64'({ohs, ohv, ohw}), 64'(3'h4));
        check("nohm_has", 64'({nhs, nhv, nhw}), 64'(3'h2));
        check("nosp_has", 64'(ns_has), 64'(3'h0));
        sn(32'h3f808000, 3'h0);
        for (int r = 0; r < 8; r++) begin
            sn(32'h3f818000, 3'(r));
            sn(32'hbf808001, 3'(r));
            sn(32'h007f8001, 3'(r));
            sn(32'h807fc000, 3'(r));
            sn(32'h00004001, 3'(r));
        end
        sn(32'h00010000, 3'h0);
        sn(32'h7f800001, 3'h0);
        sn(32'hffc12345, 3'h1);
        sn(32'h7f7fffff, 3'h0);
        sn(32'h7f7fffff, 3'h1);
        sn(32'hff800000, 3'h2);
        sw(16'h4049);
        sw(16'hff80);
        sw(16'h0003);
        sw(16'h7f81);
        cyc(1'b1, bf16_convert_pkg::vector_narrow_to_bfloat, 3'h4, 64'h007f8001_7f800001);
        cyc(1'b1, bf16_convert_pkg::vector_widen_from_bfloat, 3'h0, 64'h0_7f81_c049);
        for (int k = 0; k < 300; k++) begin
            rnd = lfsr(rnd);
            a = rnd;
            rnd = lfsr(rnd);
            cyc(rnd[5] | rnd[6], bf16_convert_pkg::conv_op_t'(rnd[1:0]), rnd[4:2], {a, rnd});
        end
        cyc(1'b0, bf16_convert_pkg::scalar_narrow_to_bfloat, 3'h0, 64'h0);
        cyc(1'b0, bf16_convert_pkg::scalar_narrow_to_bfloat, 3'h0, 64'h0);
        check("sticky", 64'(st), 64'(exp_st));
        end_of_test();
    end
endmodule : tb_bf16_fp32_convert_flags
`default_nettype wire
